// File: rtl/timer16_counter_capture.sv
// Purpose: 16-bit up/down counter with input capture on a byte bus
// Assumes: single 20 MHz clock, byte register port from the core
// Notes:   one shared high-byte latch serves every 16-bit register
`timescale 1ns/1ns
`default_nettype none
module timer16_counter_capture #(
  parameter int INSTANCE = 1
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // Register port from the core
  input  wire logic [3:0]               regAddr,
  input  wire logic [7:0]               regWdata,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic      [7:0]               regRdata,
  // Interrupt service acknowledges
  input  wire logic                     captureAck,
  input  wire logic                     overflowAck,
  // Event inputs
  input  wire logic                     capture_pin,
  input  wire logic                     comparator_out,
  input  wire logic                     extClockPin,
  // Indications
  output logic                          topHit,
  output logic                          bottomHit,
  output logic                          captureIrq,
  output logic                          overflowIrq
);
  import timer16_pkg::*;

  logic [15:0] count_value_r;
  logic [15:0] capture_value_r;
  logic [7:0]  holdLatch_r;
  logic [7:0]  control_a_r;
  logic [7:0]  control_b_r;
  logic        overflow_flag_r;
  logic        capture_flag_r;
  logic        capture_irq_enable_r;
  logic        overflowIrqEn_r;
  logic        countDown_r;
  logic [PRE_W-1:0] prescale_r;
  logic [1:0]  capSync_r;
  logic [1:0]  cmpSync_r;
  logic [1:0]  extSync_r;
  logic        capPrev_r;
  logic        extPrev_r;
  logic [3:0]  wave_mode;
  logic [2:0]  source_select;
  logic        tick_clock;
  logic        capSrc;
  logic        captureHit;
  logic        wrCountLow;
  logic        rdCountLow;
  logic        rdCapLow;
  logic        atTop;

  // Field extraction across the two control registers
  assign wave_mode     = {control_b_r[WAVE_HI_POS+1:WAVE_HI_POS],
                          control_a_r[WAVE_LO_POS+1:WAVE_LO_POS]};
  assign source_select = control_b_r[SRC_POS+2:SRC_POS];

  // Access strobes on the low-byte locations
  assign wrCountLow = regWrite && (regAddr == OFS_COUNT_LOW);
  assign rdCountLow = regRead  && (regAddr == OFS_COUNT_LOW);
  assign rdCapLow   = regRead  && (regAddr == OFS_CAPTURE_LOW);

  // Free-running prescaler on the system clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prescale_r <= '0;
    end else begin
      prescale_r <= prescale_r + 1'b1;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      capSync_r <= 2'b00;
      cmpSync_r <= 2'b00;
      extSync_r <= 2'b00;
      capPrev_r <= 1'b0;
      extPrev_r <= 1'b0;
    end else begin
      capSync_r <= {capSync_r[0], capture_pin};
      cmpSync_r <= {cmpSync_r[0], comparator_out};
      extSync_r <= {extSync_r[0], extClockPin};
      capPrev_r <= capSrc;
      extPrev_r <= extSync_r[1];
    end
  end

  // Tick selection; divider taps are one-cycle enables
  always_comb begin
    case (source_select)
      SRC_STOP:   tick_clock = 1'b0;
      SRC_DIV1:   tick_clock = 1'b1;
      SRC_DIV8:   tick_clock = (prescale_r[2:0] == 3'h7);
      SRC_DIV64:  tick_clock = (prescale_r[5:0] == 6'h3F);
      SRC_DIV256: tick_clock = (prescale_r[7:0] == 8'hFF);
      SRC_DIV1K:  tick_clock = (prescale_r == 10'h3FF);
      SRC_EXTF:   tick_clock = extPrev_r && !extSync_r[1];
      SRC_EXTR:   tick_clock = !extPrev_r && extSync_r[1];
      default:    tick_clock = 1'b0;
    endcase
  end

  // Comparator path exists only on instance 1
  assign capSrc = (INSTANCE == 1 && control_b_r[CAPSRC_POS]) ?
                  cmpSync_r[1] : capSync_r[1];

  // Edge detector qualified by the configured sense
  assign captureHit = control_b_r[EDGE_POS] ?
                      (capSrc && !capPrev_r) :
                      (!capSrc && capPrev_r);

  // Top depends on mode: capture register in clear mode, else max
  assign atTop = (wave_mode == WAVE_CLR_CAP) ?
                 (count_value_r == capture_value_r) :
                 (count_value_r == COUNT_MAX);

  // Counter: core write first, then clear, then step
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_value_r <= RESET_WORD;
    end else if (wrCountLow) begin
      count_value_r <= {holdLatch_r, regWdata};
    end else if (tick_clock) begin
      if (wave_mode == WAVE_CLR_CAP && atTop) begin
        count_value_r <= COUNT_BOTTOM;
      end else if (countDown_r) begin
        count_value_r <= count_value_r - COUNT_ONE;
      end else begin
        count_value_r <= count_value_r + COUNT_ONE;
      end
    end
  end

  // Direction control; only the dual-slope mode turns round
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      countDown_r <= 1'b0;
    end else if (wave_mode != WAVE_UPDOWN) begin
      countDown_r <= 1'b0;
    end else if (tick_clock && !wrCountLow) begin
      if (!countDown_r && count_value_r == COUNT_MAX - COUNT_ONE) begin
        countDown_r <= 1'b1;
      end else if (countDown_r && count_value_r == COUNT_ONE) begin
        countDown_r <= 1'b0;
      end
    end
  end

  // Shared latch: high-byte writes, low-byte reads load it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      holdLatch_r <= RESET_BYTE;
    end else if (regWrite && (regAddr == OFS_COUNT_HIGH ||
                              regAddr == OFS_CAPTURE_HIGH)) begin
      holdLatch_r <= regWdata;
    end else if (rdCountLow) begin
      holdLatch_r <= count_value_r[15:8];
    end else if (rdCapLow) begin
      holdLatch_r <= capture_value_r[15:8];
    end
  end

  // Capture register; writable only in the mode that uses it as top
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      capture_value_r <= RESET_WORD;
    end else if (wave_mode == WAVE_CLR_CAP) begin
      if (regWrite && regAddr == OFS_CAPTURE_LOW) begin
        capture_value_r <= {holdLatch_r, regWdata};
      end
    end else if (captureHit) begin
      capture_value_r <= count_value_r;
    end
  end

  // Capture flag; a new capture beats a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      capture_flag_r <= 1'b0;
    end else if (captureHit && wave_mode != WAVE_CLR_CAP) begin
      capture_flag_r <= 1'b1;
    end else if (captureAck || (regWrite && regAddr == OFS_FLAGS &&
                                regWdata[CAPF_POS])) begin
      capture_flag_r <= 1'b0;
    end
  end

  // Overflow flag: at max in normal mode, at bottom in dual slope
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      overflow_flag_r <= 1'b0;
    end else if (tick_clock && !wrCountLow &&
                 ((wave_mode == WAVE_UPDOWN && countDown_r &&
                   count_value_r == COUNT_ONE) ||
                  (wave_mode != WAVE_UPDOWN && atTop))) begin
      overflow_flag_r <= 1'b1;
    end else if (overflowAck || (regWrite && regAddr == OFS_FLAGS &&
                                 regWdata[OVF_POS])) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // Control and mask registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_a_r          <= RESET_BYTE;
      control_b_r          <= RESET_BYTE;
      capture_irq_enable_r <= 1'b0;
      overflowIrqEn_r      <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == OFS_CONTROL_A) begin
        control_a_r <= regWdata;
      end else if (regAddr == OFS_CONTROL_B) begin
        control_b_r <= regWdata;
      end else if (regAddr == OFS_IRQ_MASK) begin
        capture_irq_enable_r <= regWdata[CAPF_POS];
        overflowIrqEn_r      <= regWdata[OVF_POS];
      end
    end
  end

  // Read data, registered; high locations return the latch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdata <= RESET_BYTE;
    end else if (!regRead) begin
      regRdata <= RESET_BYTE;
    end else if (regAddr == OFS_COUNT_LOW) begin
      regRdata <= count_value_r[7:0];
    end else if (regAddr == OFS_COUNT_HIGH ||
                 regAddr == OFS_CAPTURE_HIGH) begin
      regRdata <= holdLatch_r;
    end else if (regAddr == OFS_CAPTURE_LOW) begin
      regRdata <= capture_value_r[7:0];
    end else if (regAddr == OFS_CONTROL_A) begin
      regRdata <= control_a_r;
    end else if (regAddr == OFS_CONTROL_B) begin
      regRdata <= control_b_r;
    end else if (regAddr == OFS_FLAGS) begin
      regRdata <= {2'b00, capture_flag_r, 4'h0, overflow_flag_r};
    end else if (regAddr == OFS_IRQ_MASK) begin
      regRdata <= {2'b00, capture_irq_enable_r, 4'h0, overflowIrqEn_r};
    end else begin
      regRdata <= RESET_BYTE;
    end
  end

  // Indications and requests, registered outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      topHit      <= 1'b0;
      bottomHit   <= 1'b0;
      captureIrq  <= 1'b0;
      overflowIrq <= 1'b0;
    end else begin
      topHit      <= atTop;
      bottomHit   <= (count_value_r == COUNT_BOTTOM);
      captureIrq  <= capture_flag_r && capture_irq_enable_r;
      overflowIrq <= overflow_flag_r && overflowIrqEn_r;
    end
  end
endmodule
`default_nettype wire

// File: rtl/timer16_pkg.sv
// Purpose: shared constants for the 16-bit timer with input capture
// Assumes: byte-wide register port, one system clock
// Notes:   offsets are register indices on the internal byte bus
package timer16_pkg;
  // Register offsets
  localparam logic [3:0] OFS_COUNT_LOW    = 4'h0;
  localparam logic [3:0] OFS_COUNT_HIGH   = 4'h1;
  localparam logic [3:0] OFS_CAPTURE_LOW  = 4'h2;
  localparam logic [3:0] OFS_CAPTURE_HIGH = 4'h3;
  localparam logic [3:0] OFS_CONTROL_A    = 4'h4;
  localparam logic [3:0] OFS_CONTROL_B    = 4'h5;
  localparam logic [3:0] OFS_FLAGS        = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK     = 4'h7;
  // Control A fields
  localparam int WAVE_LO_POS = 0;      // wave_mode[1:0]
  // Control B fields
  localparam int SRC_POS     = 0;      // source_select[2:0]
  localparam int WAVE_HI_POS = 3;      // wave_mode[3:2]
  localparam int EDGE_POS    = 6;      // 1 = rising edge captures
  localparam int CAPSRC_POS  = 7;      // 1 = comparator_out source
  // Flags and mask fields
  localparam int OVF_POS     = 0;
  localparam int CAPF_POS    = 5;
  // Reset values
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  // Count limits
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  // Source select codes
  localparam logic [2:0] SRC_STOP   = 3'h0;
  localparam logic [2:0] SRC_DIV1   = 3'h1;
  localparam logic [2:0] SRC_DIV8   = 3'h2;
  localparam logic [2:0] SRC_DIV64  = 3'h3;
  localparam logic [2:0] SRC_DIV256 = 3'h4;
  localparam logic [2:0] SRC_DIV1K  = 3'h5;
  localparam logic [2:0] SRC_EXTF   = 3'h6;
  localparam logic [2:0] SRC_EXTR   = 3'h7;
  // Wave mode codes used by this counter
  localparam logic [3:0] WAVE_NORMAL  = 4'h0;
  localparam logic [3:0] WAVE_UPDOWN  = 4'h1;
  localparam logic [3:0] WAVE_CLR_CAP = 4'hC;
  // Prescaler width
  localparam int PRE_W = 10;
endpackage

// File: test/core_model.sv
// Purpose: core-side master of the byte register port
// Assumes: tasks are entered just after a rising edge
// Notes:   strobes stay up across back-to-back calls; idle drops them
`timescale 1ns/1ns
`default_nettype none
module core_model (
  // Clock
  input  wire logic       clock,
  // Register port
  output logic      [3:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWrite,
  output logic            regRead,
  input  wire logic [7:0] regRdata
);
  // Quiet bus from time zero
  initial begin
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // Byte write, taken at the next edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regWrite <= 1'b1;
    regRead <= 1'b0;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
  endtask
  // Byte read; data is registered at the taking edge and sampled 1 ns later
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    regRead <= 1'b1;
    regWrite <= 1'b0;
    regAddr <= a;
    @(posedge clock);
    #1 d = regRdata;
  endtask
  // Word write, uninterrupted, upper byte first
  task automatic wr16(input logic [3:0] lo, input logic [15:0] w);
    wr(lo + 4'h1, w[15:8]);
    wr(lo, w[7:0]);
  endtask
  // Word read, lower byte first so the latch holds the pair
  task automatic rd16(input logic [3:0] lo, output logic [15:0] w);
    rd(lo, w[7:0]);
    rd(lo + 4'h1, w[15:8]);
  endtask
  // Slow core: strobes down for n cycles
  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// File: test/tb_timer16_counter_capture.sv
// Purpose: self-checking bench for the timer with capture
// Assumes: core_model drives the register port
// Notes:   random words from a fixed seed; counter stopped for captures
`timescale 1ns/1ns
`default_nettype none
module tb_timer16_counter_capture;
  import timer16_pkg::*;
  logic        clock, resetn, captureAck, overflowAck, capture_pin;
  logic        comparator_out, extClockPin, regWrite, regRead;
  logic        topHit, bottomHit, captureIrq, overflowIrq;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, b, b0;
  logic [15:0] w, v;
  int          n_mismatch, compares, cyc, k, m;
  int          dv[8] = '{16, 1, 8, 64, 256, 1024, 8, 8};
  timer16_counter_capture timer16_counter_capture_i (
    .clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .captureAck(captureAck),
    .overflowAck(overflowAck), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .extClockPin(extClockPin),
    .topHit(topHit), .bottomHit(bottomHit), .captureIrq(captureIrq),
    .overflowIrq(overflowIrq));
  core_model core_model_i (
    .clock(clock), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic [7:0] d);
    core_model_i.wr(a, d);
  endtask
  task automatic rdb(input logic [3:0] a, input logic [7:0] e);
    core_model_i.rd(a, b);
    chk(16'(e), 16'(b));
  endtask
  task automatic rdw(input logic [3:0] lo, input logic [15:0] e);
    core_model_i.rd16(lo, v);
    chk(e, v);
  endtask
  // Drive the chosen capture input, then let the sync chain settle
  // The unselected input wanders at random and must be ignored
  task automatic pin(input logic c, input logic l);
    if (c) begin
      comparator_out <= l;
      capture_pin    <= 1'($urandom);
    end else begin
      capture_pin    <= l;
      comparator_out <= 1'($urandom);
    end
    core_model_i.idle(6);
  endtask
  // Low byte i ticks after FFFC; mode 1 turns back at the top
  function automatic logic [7:0] lowAt(input int md, input int i);
    if (md == 1 && i > 3) return 8'(255 - (i - 3));
    return 8'(252 + i);
  endfunction
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Hang guard, well above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    resetn = 1'b0;
    captureAck = 1'b0;
    overflowAck = 1'b0;
    capture_pin = 1'b0;
    comparator_out = 1'b0;
    extClockPin = 1'b0;
    w = $urandom(32'hD0A4);
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rdw(OFS_COUNT_LOW, RESET_WORD);
    rdw(OFS_CAPTURE_LOW, RESET_WORD);
    rdb(OFS_FLAGS, RESET_BYTE);
    $display("test reset done");
    // Words written while counting: the write wins the tick
    wb(OFS_CONTROL_B, SRC_DIV1);
    for (k = 0; k < 5; k++) begin
      w = k == 0 ? COUNT_BOTTOM : k == 1 ? COUNT_MAX : 16'($urandom);
      core_model_i.wr16(OFS_COUNT_LOW, w);
      rdw(OFS_COUNT_LOW, w);
    end
    wb(OFS_CONTROL_B, SRC_STOP);
    core_model_i.wr16(OFS_COUNT_LOW, w);
    wb(OFS_COUNT_HIGH, 8'hA5);
    rdb(OFS_COUNT_HIGH, 8'hA5);
    rdw(OFS_COUNT_LOW, w);
    $display("test access done");
    // Every source code: two ticks per window, none when stopped
    for (k = 0; k < 8; k++) begin
      wb(OFS_CONTROL_B, 8'(k));
      core_model_i.rd(OFS_COUNT_LOW, b0);
      if (k < 6) extClockPin <= 1'($urandom);
      if (k >= 6) repeat (2) begin
        extClockPin <= 1'b1;
        core_model_i.idle(4);
        extClockPin <= 1'b0;
        core_model_i.idle(4);
      end
      core_model_i.idle(2 * dv[k] - 1);
      rdb(OFS_COUNT_LOW, b0 + 8'(k > 0 ? 2 : 0));
    end
    $display("test sources done");
    // Modes 0 and 1 from FFFC: wrap and overflow, or turn at the top
    wb(OFS_IRQ_MASK, 8'h01);
    for (m = 0; m < 2; m++) begin
      wb(OFS_CONTROL_A, 8'(m));
      core_model_i.wr16(OFS_COUNT_LOW, 16'hFFFC);
      wb(OFS_CONTROL_B, SRC_DIV1);
      core_model_i.rd(OFS_COUNT_LOW, b0);
      for (k = 1; k < 8; k++) rdb(OFS_COUNT_LOW, lowAt(m, int'(b0 - 8'hFC) + k));
      wb(OFS_CONTROL_B, SRC_STOP);
    end
    chk(16'h0001, 16'(overflowIrq));
    overflowAck <= 1'b1;
    core_model_i.idle(1);
    overflowAck <= 1'b0;
    core_model_i.idle(2);
    chk(16'h0000, 16'(overflowIrq));
    wb(OFS_CONTROL_A, 8'h00);
    $display("test modes done");
    // Pin and comparator, both senses; wrong edge first
    wb(OFS_IRQ_MASK, 8'h21);
    for (k = 0; k < 4; k++) begin
      w = 16'($urandom);
      core_model_i.wr16(OFS_COUNT_LOW, w);
      wb(OFS_CONTROL_B, {k[1], k[0], 6'h00});
      pin(k[1], k[0]);
      wb(OFS_FLAGS, 8'h21);
      pin(k[1], !k[0]);
      rdb(OFS_FLAGS, 8'h00);
      pin(k[1], k[0]);
      rdb(OFS_FLAGS, 8'h20);
      chk(16'h0001, 16'(captureIrq));
      rdw(OFS_CAPTURE_LOW, w);
      captureAck <= 1'b1;
      core_model_i.idle(1);
      captureAck <= 1'b0;
      core_model_i.idle(3);
      chk(16'h0000, 16'(captureIrq));
    end
    $display("test capture done");
    // Refused writes: capture low outside mode C, unmapped places
    core_model_i.wr16(OFS_CAPTURE_LOW, ~w);
    rdw(OFS_CAPTURE_LOW, w);
    // Clear-at-capture mode: capture writable, count wraps at it
    wb(OFS_CONTROL_B, 8'h18);
    core_model_i.wr16(OFS_CAPTURE_LOW, 16'h0005);
    rdw(OFS_CAPTURE_LOW, 16'h0005);
    core_model_i.wr16(OFS_COUNT_LOW, 16'h0003);
    wb(OFS_CONTROL_B, 8'h19);
    rdb(OFS_COUNT_LOW, 8'h03);
    rdb(OFS_COUNT_LOW, 8'h04);
    rdb(OFS_COUNT_LOW, 8'h05);
    rdb(OFS_COUNT_LOW, 8'h00);
    wb(OFS_CONTROL_B, SRC_STOP);
    for (k = 8; k < 16; k++) begin
      wb(4'(k), 8'hFF);
      rdb(4'(k), 8'h00);
    end
    wb(OFS_IRQ_MASK, 8'h00);
    // Second reset in mid-run
    resetn <= 1'b0;
    core_model_i.idle(2);
    resetn <= 1'b1;
    core_model_i.idle(1);
    rdw(OFS_COUNT_LOW, RESET_WORD);
    $display("test refuse done");
    end_sim();
  end
endmodule
`default_nettype wire

// File: test/timer16_chk.sv
// Purpose: port assertions for the 16-bit timer with capture
// Assumes: wave modes 0 and 1 whenever a full word is written
// Notes:   bound into the design; helper counter tracks quiet inputs
`timescale 1ns/1ns
`default_nettype none
module timer16_chk (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  // Events and indications
  input wire logic       captureAck,
  input wire logic       capture_pin,
  input wire logic       comparator_out,
  input wire logic       topHit,
  input wire logic       bottomHit,
  input wire logic       captureIrq,
  input wire logic       overflowIrq
);
  logic [2:0] quiet_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Cycles since a capture input moved; a late edge may refill the flag
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) quiet_r <= 3'h0;
    else if ($changed(capture_pin) || $changed(comparator_out)) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  a_read_idle_zero: assert property (
    !regRead |=> regRdata == 8'h00) else $error("read data not idle");
  a_unmapped_read: assert property (
    regRead && regAddr[3] |=> regRdata == 8'h00) else $error("unmapped data");
  a_zero_word: assert property (
    regWrite && regAddr == 4'h1 && regWdata == 8'h00 ##1
    regWrite && regAddr == 4'h0 && regWdata == 8'h00 |=> ##1 bottomHit)
    else $error("bottom missed after zero write");
  a_max_word: assert property (
    regWrite && regAddr == 4'h1 && regWdata == 8'hFF ##1
    regWrite && regAddr == 4'h0 && regWdata == 8'hFF |=> ##1 topHit)
    else $error("top missed after max write");
  a_top_bottom: assert property (
    bottomHit |-> !topHit) else $error("top and bottom together");
  a_reset_state: assert property (
    $rose(resetn) |-> !topHit && !captureIrq && !overflowIrq ##1 bottomHit)
    else $error("state after reset");
  a_mask_clear: assert property (
    regWrite && regAddr == 4'h7 && regWdata == 8'h00
    |=> ##1 !captureIrq && !overflowIrq) else $error("masked request");
  a_flag_clear: assert property (
    (captureAck || regWrite && regAddr == 4'h6 && regWdata[5])
    && quiet_r >= 3'h4 |=> ##1 !captureIrq) else $error("flag not cleared");
endmodule
bind timer16_counter_capture timer16_chk timer16_chk_i (
  .clock(clock), .resetn(resetn), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .captureAck(captureAck),
  .capture_pin(capture_pin), .comparator_out(comparator_out),
  .topHit(topHit), .bottomHit(bottomHit), .captureIrq(captureIrq),
  .overflowIrq(overflowIrq));
`default_nettype wire
